// ---- rtl/lcdhri_pkg.sv ----
// constants, types and pin bundle of the display host register interface
package lcdhri_pkg;
    // core clock and timing
    localparam int CLK_PERIOD_NS    = 10;                 // 100 mhz core
    localparam int CORE_CLK_HZ      = 100_000_000;
    localparam int OSC_HZ           = 45_000;             // nominal oscillator
    localparam int OSC_DIV_CYCLES   = CORE_CLK_HZ / OSC_HZ;
    localparam int RESET_HOLD_NS    = 1_200_000;          // 1.2 ms low on pin
    localparam int RESET_HOLD_CYCLES =
        (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSY_OSC_TICKS   = 2;                  // oscillator ticks busy

    // widths and depths
    localparam int DATA_W      = 8;
    localparam int PTR_W       = 7;
    localparam int GLYPH_W     = 5;
    localparam int DISP_DEPTH  = 12;
    localparam int GLYPH_DEPTH = 32;
    localparam int ICON_DEPTH  = 5;
    localparam int BUSY_BIT    = 7;                       // data_bit_seven
    localparam logic [3:0] FRAME_BITS = 4'h8;
    localparam logic [PTR_W-1:0] DISP_LAST  = 7'h0b;
    localparam logic [PTR_W-1:0] GLYPH_LAST = 7'h1f;
    localparam logic [PTR_W-1:0] ICON_LAST  = 7'h04;
    localparam logic [3:0] DISP_LAST_POS    = 4'hb;
    localparam logic [4:0] DISP_DEPTH_5     = 5'h0c;
    localparam logic [2:0] BUSY_TICKS_3     = 3'h2;

    // command codes, matched on the upper bits
    localparam logic [0:0] OP_DISP_SET   = 1'h1;   // 1aaaaaaa
    localparam logic [1:0] OP_GLYPH_SET  = 2'h1;   // 01aaaaaa
    localparam logic [2:0] OP_ICON_SET   = 3'h1;   // 001aaaaa
    localparam logic [3:0] OP_SHIFT      = 4'h1;   // 0001_1r00, r=1 right
    localparam logic [5:0] OP_ENTRY      = 6'h01;  // 000001i0, i=1 increment
    localparam int SHIFT_DIR_BIT = 2;
    localparam int ENTRY_INC_BIT = 1;

    // which memory data accesses target
    typedef enum logic [1:0] {
        LCDHRI_MEM_DISP,
        LCDHRI_MEM_GLYPH,
        LCDHRI_MEM_ICON
    } lcdhri_mem_t;

    // serial frame state
    typedef enum logic [1:0] {
        LCDHRI_SER_IDLE,
        LCDHRI_SER_SHIFT,
        LCDHRI_SER_WAIT
    } lcdhri_ser_t;

    // pins from outside the core clock domain
    typedef struct packed {
        logic cs_n;        // chip select, low active
        logic scl;         // shift clock from host
        logic serial_data_line;         // serial_data_line input side
        logic rs;          // register_select
        logic rw;          // direction, 1 = read
        logic osc;         // oscillator_input
        logic osc_ext;     // 1 = use external oscillator
        logic rst_n;       // reset pin, low active
    } lcdhri_pins_t;

    localparam int PIN_N = 8;
    localparam lcdhri_pins_t PINS_RST = 8'h81;   // cs_n and rst_n idle high
endpackage

// ---- rtl/lcdhri_top.sv ----
// serial host register interface of a one-line character display controller
`timescale 1ns/1ns
`default_nettype none
module lcdhri_top #(
    parameter int RESET_HOLD_CYCLES = lcdhri_pkg::RESET_HOLD_CYCLES
) (
    input  wire logic                 core_clk_i,
    input  wire logic                 resetn_i,
    input  wire lcdhri_pkg::lcdhri_pins_t pins_i,     // raw pin levels
    input  wire logic [3:0]           disp_pos_i,     // position being driven
    output logic                      sio_o,          // serial data out
    output logic                      sio_oe_o,       // high while driving
    output logic                      busy_o,         // busy_indicator copy
    output logic [7:0]                disp_code_o     // code at disp_pos_i
);
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: three flops, change taken when 2nd and 3rd agree
    logic [2:0]               sync_ff [lcdhri_pkg::PIN_N]; // per pin chain
    lcdhri_pkg::lcdhri_pins_t lvl_ff;                      // filtered levels
    lcdhri_pkg::lcdhri_pins_t prev_ff;                     // last levels
    logic                     sys_rst;                     // combined reset
    logic                     pin_rst_ff;                  // from reset pin

    genvar gi;
    generate
        for (gi = 0; gi < lcdhri_pkg::PIN_N; gi++) begin : g_sync
            // shift chain, first flop read only by the second
            always_ff @(posedge core_clk_i) begin
                if (!resetn_i) begin
                    sync_ff[gi] <= {3{lcdhri_pkg::PINS_RST[gi]}};
                end else begin
                    sync_ff[gi] <= {sync_ff[gi][1:0], pins_i[gi]};
                end
            end
            // accept a level only once it stood two samples
            always_ff @(posedge core_clk_i) begin
                if (!resetn_i) begin
                    lvl_ff[gi] <= lcdhri_pkg::PINS_RST[gi];
                end else if (sync_ff[gi][1] == sync_ff[gi][2]) begin
                    lvl_ff[gi] <= sync_ff[gi][2];
                end
            end
        end
    endgenerate

    // previous levels for edge detection
    always_ff @(posedge core_clk_i) begin
        if (sys_rst) begin
            prev_ff <= lcdhri_pkg::PINS_RST;
        end else begin
            prev_ff <= lvl_ff;
        end
    end

    wire cs_fall  = prev_ff.cs_n & ~lvl_ff.cs_n;
    wire cs_rise  = ~prev_ff.cs_n & lvl_ff.cs_n;
    wire scl_rise = ~prev_ff.scl & lvl_ff.scl;
    wire scl_fall = prev_ff.scl & ~lvl_ff.scl;

    ////////////////////////////////////////////////////////////////////////
    // reset pin: low longer than the hold time resets the interface registers; the memories keep their contents
    logic [$clog2(RESET_HOLD_CYCLES+1)-1:0] rst_cnt_ff;   // low-time count

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i || lvl_ff.rst_n) begin
            rst_cnt_ff <= '0;
            pin_rst_ff <= 1'b0;
        end else if (rst_cnt_ff == ($bits(rst_cnt_ff))'(RESET_HOLD_CYCLES)) begin
            pin_rst_ff <= 1'b1;
        end else begin
            rst_cnt_ff <= rst_cnt_ff + 1'b1;
        end
    end
    assign sys_rst = !resetn_i || pin_rst_ff;

    ////////////////////////////////////////////////////////////////////////
    // oscillator tick: internal divider or external clock edge
    logic [$clog2(lcdhri_pkg::OSC_DIV_CYCLES)-1:0] div_ff; // internal divider
    logic                                          tick_ff; // one-cycle tick

    // external edges are filtered like any pin; internal is a divider
    always_ff @(posedge core_clk_i) begin
        if (sys_rst) begin
            div_ff  <= '0;
            tick_ff <= 1'b0;
        end else if (lvl_ff.osc_ext) begin
            div_ff  <= '0;
            tick_ff <= ~prev_ff.osc & lvl_ff.osc;
        end else if (div_ff == ($bits(div_ff))'(lcdhri_pkg::OSC_DIV_CYCLES-1))
        begin
            div_ff  <= '0;
            tick_ff <= 1'b1;
        end else begin
            div_ff  <= div_ff + 1'b1;
            tick_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial frame engine: sample on scl rise, shift out on scl fall
    lcdhri_pkg::lcdhri_ser_t ser_ff;         // frame state
    logic [3:0]              bit_cnt_ff;     // bits taken so far
    logic [7:0]              shin_ff;        // received byte
    logic [7:0]              shout_ff;       // byte being sent
    logic                    frm_rs_ff;      // register_select of frame
    logic                    frm_rw_ff;      // direction of frame
    logic                    done_ff;        // one-cycle end of frame
    logic                    busy_ff;        // busy_indicator
    logic [6:0]              ptr_ff;         // address_pointer
    logic [7:0]              dbuf_ff;        // data_buffer_register

    always_ff @(posedge core_clk_i) begin
        if (sys_rst) begin
            ser_ff     <= lcdhri_pkg::LCDHRI_SER_IDLE;
            bit_cnt_ff <= '0;
            shin_ff    <= '0;
            shout_ff   <= '0;
            frm_rs_ff  <= 1'b0;
            frm_rw_ff  <= 1'b0;
            done_ff    <= 1'b0;
            sio_o      <= 1'b0;
            sio_oe_o   <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (cs_rise) begin
                // frame abandoned or closed: release the line
                ser_ff   <= lcdhri_pkg::LCDHRI_SER_IDLE;
                sio_oe_o <= 1'b0;
            end else begin
                unique case (ser_ff)
                    lcdhri_pkg::LCDHRI_SER_IDLE: begin
                        if (cs_fall) begin
                            ser_ff     <= lcdhri_pkg::LCDHRI_SER_SHIFT;
                            bit_cnt_ff <= '0;
                            frm_rs_ff  <= lvl_ff.rs;
                            frm_rw_ff  <= lvl_ff.rw;
                            sio_oe_o   <= lvl_ff.rw;
                            // status lets busy through even while busy
                            if (!lvl_ff.rs) begin
                                shout_ff <= {busy_ff, ptr_ff};
                                sio_o    <= busy_ff;
                            end else begin
                                shout_ff <= dbuf_ff;
                                sio_o    <= dbuf_ff[7];
                            end
                        end
                    end
                    lcdhri_pkg::LCDHRI_SER_SHIFT: begin
                        if (scl_rise) begin
                            shin_ff    <= {shin_ff[6:0], lvl_ff.serial_data_line};
                            bit_cnt_ff <= bit_cnt_ff + 1'b1;
                            if (bit_cnt_ff == lcdhri_pkg::FRAME_BITS - 1'b1)
                            begin
                                ser_ff  <= lcdhri_pkg::LCDHRI_SER_WAIT;
                                done_ff <= 1'b1;
                            end
                        end else if (scl_fall && frm_rw_ff) begin
                            shout_ff <= {shout_ff[6:0], 1'b0};
                            sio_o    <= shout_ff[6];
                        end
                    end
                    lcdhri_pkg::LCDHRI_SER_WAIT: begin
                        // extra clocks after a full byte are ignored
                        ser_ff <= lcdhri_pkg::LCDHRI_SER_WAIT;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decode of finished frames; writes while busy are dropped
    logic [7:0]              cmd_ff;         // command_register, write-only
    lcdhri_pkg::lcdhri_mem_t sel_ff;         // selected memory
    logic                    inc_ff;         // 1 = pointer counts up
    logic [3:0]              shift_ff;       // display rotation 0..11
    logic                    fetch_ff;       // prefetch one cycle later
    logic [2:0]              tick_cnt_ff;    // oscillator ticks while busy

    wire accept = done_ff && !busy_ff && !(frm_rw_ff && !frm_rs_ff);
    wire cmd_wr = accept && !frm_rs_ff && !frm_rw_ff;
    wire dat_wr = accept && frm_rs_ff && !frm_rw_ff;
    wire dat_rd = accept && frm_rs_ff && frm_rw_ff;
    wire is_disp  = shin_ff[7] == lcdhri_pkg::OP_DISP_SET;
    wire is_glyph = shin_ff[7:6] == lcdhri_pkg::OP_GLYPH_SET;
    wire is_icon  = shin_ff[7:5] == lcdhri_pkg::OP_ICON_SET;
    wire is_shift = shin_ff[7:4] == lcdhri_pkg::OP_SHIFT;
    wire is_entry = shin_ff[7:2] == lcdhri_pkg::OP_ENTRY;
    wire addr_set = cmd_wr && (is_disp || is_glyph || is_icon);

    // last address of the selected memory, for wrapping
    logic [6:0] last_addr;
    always_comb begin
        unique case (sel_ff)
            lcdhri_pkg::LCDHRI_MEM_DISP:  last_addr = lcdhri_pkg::DISP_LAST;
            lcdhri_pkg::LCDHRI_MEM_GLYPH: last_addr = lcdhri_pkg::GLYPH_LAST;
            lcdhri_pkg::LCDHRI_MEM_ICON:  last_addr = lcdhri_pkg::ICON_LAST;
            default:                      last_addr = lcdhri_pkg::DISP_LAST;
        endcase
    end

    // command register holds the last instruction, never shifted out
    always_ff @(posedge core_clk_i) begin
        if (sys_rst) begin
            cmd_ff <= '0;
        end else if (cmd_wr) begin
            cmd_ff <= shin_ff;
        end
    end

    // address pointer and memory select
    always_ff @(posedge core_clk_i) begin
        if (sys_rst) begin
            ptr_ff <= '0;
            sel_ff <= lcdhri_pkg::LCDHRI_MEM_DISP;
        end else if (addr_set) begin
            if (is_disp) begin
                sel_ff <= lcdhri_pkg::LCDHRI_MEM_DISP;
                ptr_ff <= shin_ff[6:0];
            end else if (is_glyph) begin
                sel_ff <= lcdhri_pkg::LCDHRI_MEM_GLYPH;
                ptr_ff <= {1'b0, shin_ff[5:0]};
            end else begin
                sel_ff <= lcdhri_pkg::LCDHRI_MEM_ICON;
                ptr_ff <= {2'b00, shin_ff[4:0]};
            end
        end else if (dat_wr || dat_rd) begin
            // wrap inside the selected memory in both directions
            if (inc_ff) begin
                ptr_ff <= (ptr_ff >= last_addr) ? '0 : ptr_ff + 1'b1;
            end else begin
                ptr_ff <= (ptr_ff == '0 || ptr_ff > last_addr) ? last_addr
                                                              : ptr_ff - 1'b1;
            end
        end
    end

    // entry direction and display rotation
    always_ff @(posedge core_clk_i) begin
        if (sys_rst) begin
            inc_ff   <= 1'b1;
            shift_ff <= '0;
        end else if (cmd_wr && is_entry) begin
            inc_ff <= shin_ff[lcdhri_pkg::ENTRY_INC_BIT];
        end else if (cmd_wr && is_shift) begin
            if (shin_ff[lcdhri_pkg::SHIFT_DIR_BIT]) begin
                shift_ff <= (shift_ff == '0) ? lcdhri_pkg::DISP_LAST_POS
                                             : shift_ff - 1'b1;
            end else begin
                shift_ff <= (shift_ff == lcdhri_pkg::DISP_LAST_POS) ? '0
                                                                : shift_ff + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // memories and data buffer
    logic [7:0] disp_mem  [lcdhri_pkg::DISP_DEPTH];
    logic [4:0] glyph_mem [lcdhri_pkg::GLYPH_DEPTH];
    logic [4:0] icon_mem  [lcdhri_pkg::ICON_DEPTH];

    // write the received byte at the pointer of the selected memory
    always_ff @(posedge core_clk_i) begin
        if (dat_wr && ptr_ff <= last_addr) begin
            unique case (sel_ff)
                lcdhri_pkg::LCDHRI_MEM_DISP:  disp_mem[ptr_ff[3:0]] <= shin_ff;
                lcdhri_pkg::LCDHRI_MEM_GLYPH: glyph_mem[ptr_ff[4:0]] <=
                                                  shin_ff[4:0];
                lcdhri_pkg::LCDHRI_MEM_ICON:  icon_mem[ptr_ff[2:0]] <=
                                                  shin_ff[4:0];
                default: ;
            endcase
        end
    end

    // prefetch runs one cycle after the pointer has settled
    always_ff @(posedge core_clk_i) begin
        if (sys_rst) begin
            fetch_ff <= 1'b0;
        end else begin
            fetch_ff <= addr_set || dat_rd || dat_wr;
        end
    end

    // data buffer: written byte first, then refilled from memory
    always_ff @(posedge core_clk_i) begin
        if (sys_rst) begin
            dbuf_ff <= '0;
        end else if (dat_wr) begin
            dbuf_ff <= shin_ff;
        end else if (fetch_ff) begin
            if (ptr_ff > last_addr) begin
                dbuf_ff <= '0;                                 // out of range
            end else begin
                unique case (sel_ff)
                    lcdhri_pkg::LCDHRI_MEM_DISP:
                        dbuf_ff <= disp_mem[ptr_ff[3:0]];
                    lcdhri_pkg::LCDHRI_MEM_GLYPH:
                        dbuf_ff <= {3'h0, glyph_mem[ptr_ff[4:0]]};
                    lcdhri_pkg::LCDHRI_MEM_ICON:
                        dbuf_ff <= {3'h0, icon_mem[ptr_ff[2:0]]};
                    default: dbuf_ff <= '0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // busy: held for a few oscillator ticks after each accepted transfer
    always_ff @(posedge core_clk_i) begin
        if (sys_rst) begin
            busy_ff     <= 1'b0;
            tick_cnt_ff <= '0;
        end else if (accept) begin
            busy_ff     <= 1'b1;
            tick_cnt_ff <= '0;
        end else if (busy_ff && tick_ff) begin
            if (tick_cnt_ff == lcdhri_pkg::BUSY_TICKS_3 - 1'b1) begin
                busy_ff <= 1'b0;
            end
            tick_cnt_ff <= tick_cnt_ff + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // display read port through the rotated mapping
    wire [4:0] pos_sum = {1'b0, disp_pos_i} + {1'b0, shift_ff};
    wire [4:0] pos_wr  = (pos_sum >= lcdhri_pkg::DISP_DEPTH_5)
                         ? pos_sum - lcdhri_pkg::DISP_DEPTH_5 : pos_sum;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst) begin
            disp_code_o <= '0;
            busy_o      <= 1'b0;
        end else begin
            disp_code_o <= disp_mem[pos_wr[3:0]];
            busy_o      <= busy_ff;
        end
    end
endmodule // lcdhri_top
`default_nettype wire

// ---- verif/lcdhri_host_model.sv ----
// host serial port model: frames one byte per chip select
`timescale 1ns/1ns
`default_nettype none
module lcdhri_host_model (
    input  wire logic sio_line_i,          // resolved data line level
    output logic      cs_n_o = 1'b1,       // chip select, low active
    output logic      scl_o  = 1'b0,       // shift clock, idles low
    output logic      sio_o  = 1'b0,       // host side of data line
    output logic      rs_o   = 1'b1,       // register_select
    output logic      rw_o   = 1'b1        // direction, 1 = read
);
    ////////////////////////////////////////////////////////////////////
    // scl idles low so the first edge of a frame is a rise: the device
    // shows bit 7 from chip select on and moves on each later fall;
    // launch while low, sample late in the high phase; bits msb first
    task automatic xfer(input logic a_rs, input logic a_rw,
                        input logic [7:0] wd, output logic [7:0] rd);
        #3;                    // keeps the link off the core clock grid when called on a clock edge
        rs_o = a_rs;
        rw_o = a_rw;
        #40 cs_n_o = 1'b0;
        #80;                   // first bit settles before any edge
        for (int i = 7; i >= 0; i--) begin
            if (!a_rw) sio_o = wd[i];
            #40 scl_o = 1'b1;  // 80 ns period, 12.5 mhz
            #40 rd[i] = sio_line_i;
            scl_o = 1'b0;      // bit taken before the device moves it
        end
        #40 cs_n_o = 1'b1;
        sio_o = ~sio_o;        // released line must not show a stale bit
        #80;
    endtask
endmodule // lcdhri_host_model
`default_nettype wire

// ---- verif/lcdhri_top_sva.sv ----
// port assertions for the display host register interface
`timescale 1ns/1ns
`default_nettype none
module lcdhri_top_sva #(
    parameter int RESET_HOLD_CYCLES = lcdhri_pkg::RESET_HOLD_CYCLES
) (
    input wire logic                     core_clk_i,
    input wire logic                     resetn_i,
    input wire lcdhri_pkg::lcdhri_pins_t pins_i,
    input wire logic [3:0]               disp_pos_i,
    input wire logic                     sio_o,
    input wire logic                     sio_oe_o,
    input wire logic                     busy_o,
    input wire logic [7:0]               disp_code_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    int unsigned low_cnt_ff;   // cycles the reset pin has stayed low

    // saturating count, so a long low never wraps back to zero
    always_ff @(posedge core_clk_i) begin
        if (pins_i.rst_n) begin
            low_cnt_ff <= 0;
        end else if (low_cnt_ff < 100000) begin
            low_cnt_ff <= low_cnt_ff + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    sequence s_status_start;   // host opens a status read frame
        $fell(pins_i.cs_n) && pins_i.rw && !pins_i.rs;
    endsequence
    sequence s_cs_idle;        // chip select long enough deselected
        pins_i.cs_n [*8];
    endsequence

    a_reset_outputs: assert property (disable iff (1'b0)
        !resetn_i |=> !sio_oe_o && !busy_o && !sio_o)
        else $error("outputs not quiet after reset");
    a_idle_no_drive: assert property (s_cs_idle |-> !sio_oe_o)
        else $error("data line driven while deselected");
    a_write_no_drive: assert property (
        !pins_i.rw [*8] |-> !sio_oe_o)
        else $error("data line driven during write");
    a_status_drives: assert property (
        s_status_start |-> ##[1:10] sio_oe_o)
        else $error("status read not answered");
    a_busy_frame: assert property (s_cs_idle |=> !$rose(busy_o))
        else $error("busy rose with no frame");
    a_busy_min: assert property ($rose(busy_o) |-> busy_o [*8])
        else $error("busy shorter than oscillator ticks");
    a_sio_stands: assert property (
        (!pins_i.scl && pins_i.rst_n && $stable(pins_i.cs_n)) [*8]
        |=> $stable(sio_o))
        else $error("data out moved without shift edge");
    a_pin_reset: assert property (
        low_cnt_ff > RESET_HOLD_CYCLES + 8 |-> !busy_o && !sio_oe_o)
        else $error("reset pin did not clear state");
endmodule // lcdhri_top_sva
bind lcdhri_top lcdhri_top_sva #(.RESET_HOLD_CYCLES(RESET_HOLD_CYCLES))
    i_sva (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .pins_i(pins_i),
    .disp_pos_i(disp_pos_i), .sio_o(sio_o), .sio_oe_o(sio_oe_o),
    .busy_o(busy_o), .disp_code_o(disp_code_o));
`default_nettype wire

// ---- verif/lcdhri_top_test.sv ----
// self-checking bench for the display host register interface
`timescale 1ns/1ns
`default_nettype none
module lcdhri_top_test;
    logic       core_clk_i = 1'b0;   // 100 mhz core clock
    logic       resetn_i   = 1'b0;   // synchronous reset, low active
    logic       osc        = 1'b0;   // fast external oscillator
    logic       osc_ext    = 1'b1;   // external keeps busy short
    logic       rst_pin_n  = 1'b1;   // reset pin level
    logic [3:0] disp_pos   = 4'h0;   // position probed
    logic       cs_n, scl, host_sio, rs, rw, dev_sio, dev_oe, busy;
    logic [7:0] disp_code, rd;
    int         errors = 0, comparisons = 0, cycles = 0;
    wire logic  sio_line = dev_oe ? dev_sio : host_sio; // line level
    lcdhri_pkg::lcdhri_pins_t pins;

    assign pins = {cs_n, scl, sio_line, rs, rw, osc, osc_ext, rst_pin_n};
    always #5 core_clk_i = ~core_clk_i;
    always #100 osc = ~osc;

    lcdhri_host_model i_host (.sio_line_i(sio_line), .cs_n_o(cs_n),
        .scl_o(scl), .sio_o(host_sio), .rs_o(rs), .rw_o(rw));
    lcdhri_top #(.RESET_HOLD_CYCLES(50)) i_dut (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .pins_i     (pins),
        .disp_pos_i (disp_pos),
        .sio_o      (dev_sio),
        .sio_oe_o   (dev_oe),
        .busy_o     (busy),
        .disp_code_o(disp_code)
    );

    ////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // poll status under a bound until the busy bit clears
    task automatic wait_idle;
        rd = 8'hff;
        for (int n = 0; n < 200 && rd[7] !== 1'b0; n++) begin
            i_host.xfer(1'b0, 1'b1, 8'h00, rd);
        end
        check({7'h00, rd[7]}, 8'h00);
    endtask
    task automatic cmd(input logic [7:0] c);
        i_host.xfer(1'b0, 1'b0, c, rd);
        wait_idle();
    endtask
    task automatic wr(input logic [7:0] d);
        i_host.xfer(1'b1, 1'b0, d, rd);
        wait_idle();
    endtask
    task automatic rdd(input logic [7:0] e);
        i_host.xfer(1'b1, 1'b1, 8'h00, rd);
        check(rd, e);
        wait_idle();
    endtask
    task automatic stat(input logic [7:0] e);
        i_host.xfer(1'b0, 1'b1, 8'h00, rd);
        check(rd, e);
    endtask
    task automatic disp(input logic [3:0] p, input logic [7:0] e);
        @(negedge core_clk_i) disp_pos = p;
        repeat (2) @(negedge core_clk_i);
        check(disp_code, e);
    endtask
    task automatic pin_reset(input int n);
        @(negedge core_clk_i) rst_pin_n = 1'b0;
        repeat (n) @(negedge core_clk_i);
        rst_pin_n = 1'b1;
        repeat (8) @(negedge core_clk_i);
    endtask

    // hang guard: the sequence needs roughly 14000 cycles
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 90000) begin
            errors++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(negedge core_clk_i);
        resetn_i = 1'b1;
        repeat (8) @(negedge core_clk_i);
        stat(8'h00);
        cmd(8'h80);
        for (int p = 0; p < 12; p++) wr(8'h41 + 8'(p));
        stat(8'h00);
        for (int p = 0; p < 12; p++) disp(4'(p), 8'h41 + 8'(p));
        cmd(8'h18);
        disp(4'hb, 8'h41);
        cmd(8'h1c);
        cmd(8'h1c);
        disp(4'h0, 8'h4c);
        cmd(8'h85);
        rdd(8'h46);
        rdd(8'h47);
        stat(8'h07);
        cmd(8'h04);
        cmd(8'h82);
        rdd(8'h43);
        rdd(8'h42);
        stat(8'h00);
        cmd(8'h06);
        cmd(8'h43);
        wr(8'hf5);
        cmd(8'h43);
        rdd(8'h15);
        cmd(8'h24);
        wr(8'hff);
        cmd(8'h24);
        rdd(8'h1f);
        stat(8'h00);
        // internal oscillator: busy long enough to refuse a write
        @(negedge core_clk_i) osc_ext = 1'b0;
        i_host.xfer(1'b0, 1'b0, 8'h80, rd);
        stat(8'h80);
        check({7'h00, busy}, 8'h01);
        i_host.xfer(1'b1, 1'b0, 8'h99, rd);
        wait_idle();
        @(negedge core_clk_i) osc_ext = 1'b1;
        stat(8'h00);
        rdd(8'h41);
        pin_reset(20);
        stat(8'h01);
        pin_reset(80);
        stat(8'h00);
        disp(4'h0, 8'h41);
        report_and_stop();
    end
endmodule // lcdhri_top_test
`default_nettype wire
